//--- hdl/adpcm_pkg.sv
package adpcm_pkg;
  // Geometry
  localparam int NUM_CH  = 8;
  localparam int CH_W    = 3;
  localparam int CNT_W   = 11;
  localparam int PCM_W   = 8;
  localparam int ADPCM_W = 5;
  localparam int STATE_W = 16;

  // Initialization lengths in master clock cycles
  localparam logic [CNT_W-1:0] POR_CYCLES  = 11'h7D0; // 2000
  localparam logic [CNT_W-1:0] WARM_CYCLES = 11'h2D6; // 726
  localparam logic [CNT_W-1:0] CNT_LAST    = 11'h001;

  // Rate select codes, high bit first
  localparam logic [1:0] RATE_32 = 2'h0;
  localparam logic [1:0] RATE_24 = 2'h1;
  localparam logic [1:0] RATE_16 = 2'h2;
  localparam logic [1:0] RATE_40 = 2'h3;

  // Code bits per rate
  localparam logic [2:0] BITS_40 = 3'h5;
  localparam logic [2:0] BITS_32 = 3'h4;
  localparam logic [2:0] BITS_24 = 3'h3;
  localparam logic [2:0] BITS_16 = 3'h2;

  // Fixed output words after a disabled channel
  localparam logic [PCM_W-1:0]   PCM_IDLE_MU = 8'hFF;
  localparam logic [PCM_W-1:0]   PCM_IDLE_A  = 8'hD5;
  localparam logic [ADPCM_W-1:0] ADPCM_IDLE  = 5'h00;

  // Default transcoder state, plain value
  localparam logic [STATE_W-1:0] STATE_DEFAULT = 16'h0000;

  typedef struct packed {
    logic [1:0]         rate;
    logic               alaw;
    logic [STATE_W-1:0] st;
  } chan_s;

  localparam chan_s CHAN_DEFAULT = '{rate: RATE_32, alaw: 1'b0, st: STATE_DEFAULT};

  typedef enum logic [2:0] {PH_HOLD = 3'h1, PH_INIT = 3'h2, PH_RUN = 3'h4} phase_e;

  typedef enum logic [4:0] {
    K_NONE = 5'h01, K_ENC = 5'h02, K_DEC = 5'h04, K_NOPA = 5'h08, K_NOPP = 5'h10
  } kind_e;

  function automatic logic [2:0] code_bits(input logic [1:0] rate);
    unique case (rate)
      RATE_32: code_bits = BITS_32;
      RATE_24: code_bits = BITS_24;
      RATE_16: code_bits = BITS_16;
      RATE_40: code_bits = BITS_40;
    endcase
  endfunction
endpackage

//--- hdl/chan_mem_if.sv
`timescale 1ns/1ns
interface chan_mem_if;
  logic                       we;
  logic [adpcm_pkg::CH_W-1:0] waddr;
  logic [adpcm_pkg::CH_W-1:0] raddr;
  adpcm_pkg::chan_s           wdata;
  adpcm_pkg::chan_s           rdata;
  modport ctl (output we, waddr, raddr, wdata, input rdata);
  modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface

//--- hdl/chan_mem.sv
`timescale 1ns/1ns
module chan_mem #(
  parameter int DEPTH = adpcm_pkg::NUM_CH
) (
  input  wire logic ref_clk_i,
  input  wire logic clk_en_i,
  chan_mem_if.mem   m
);
  adpcm_pkg::chan_s mem_q [DEPTH];
  adpcm_pkg::chan_s rdata_q;

  // One write port, registered read port
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      if (m.we) begin
        mem_q[m.waddr] <= m.wdata;
      end
      rdata_q <= mem_q[m.raddr];
    end
  end

  assign m.rdata = rdata_q;
endmodule

//--- hdl/adpcm_channel_control.sv
`timescale 1ns/1ns
module adpcm_channel_control (
  input  wire logic                            ref_clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            clk_en_i,
  input  wire logic                            strobe_i,
  input  wire logic                            pcm_shift_clock_i,
  input  wire logic                            adpcm_shift_clock_i,
  input  wire logic                            direction_select_i,
  input  wire logic                            companding_select_i,
  input  wire logic                            enable_i,
  input  wire logic                            init_i,
  input  wire logic                            rate_select_high_i,
  input  wire logic                            rate_select_low_i,
  input  wire logic                            warm_reset_n_i,
  input  wire logic                            pcm_serial_in_i,
  input  wire logic                            adpcm_serial_in_i,
  input  wire logic                            core_done_i,
  input  wire logic [adpcm_pkg::PCM_W-1:0]     core_result_i,
  input  wire logic [adpcm_pkg::STATE_W-1:0]   core_state_i,
  output logic                                 adpcm_serial_out_o,
  output logic                                 adpcm_serial_out_oe_o,
  output logic                                 pcm_serial_out_o,
  output logic                                 pcm_serial_out_oe_o,
  output logic                                 init_busy_o,
  output logic                                 chan_idle_o,
  output logic                                 core_req_o,
  output logic                                 core_encode_o,
  output logic [adpcm_pkg::PCM_W-1:0]          core_data_o,
  output logic [1:0]                           core_rate_o,
  output logic                                 core_alaw_o,
  output logic [adpcm_pkg::STATE_W-1:0]        core_state_o
);
  localparam int SYNC_W = 11;

  logic                          rst_meta_q, rst_n;
  logic [SYNC_W-1:0]             sync1_q, sync2_q;
  logic                          wr_meta_q, wr_s;
  logic [2:0]                    prev_q;
  logic                          ce_s, pck_s, ack_s, dir_s, comp_s, en_s, init_s;
  logic                          rhi_s, rlo_s, pin_s, ain_s;
  logic                          ce_fall, ce_rise, p_fall, p_rise, a_fall, a_rise, run_ok;

  adpcm_pkg::phase_e             phase_q, phase_d;
  adpcm_pkg::kind_e              pend_kind_q, pend_kind_d, out_kind_q, out_kind_d;
  logic [adpcm_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [adpcm_pkg::PCM_W-1:0]   pcm_in_q, pcm_in_d, pcmw_q, pcmw_d, res_q, res_d;
  logic [adpcm_pkg::ADPCM_W-1:0] ad_in_q, ad_in_d, adw_q, adw_d, code;
  logic [2:0]                    aidx_q, aidx_d, pidx_q, pidx_d, alen_q, alen_d, nb;
  logic [1:0]                    pend_rate_q, pend_rate_d;
  logic                          pend_alaw_q, pend_alaw_d, busy_q, busy_d;
  logic [adpcm_pkg::CH_W-1:0]    chan_q, chan_d, core_chan_q, core_chan_d;
  logic                          ad_o_d, ad_oe_d, pcm_o_d, pcm_oe_d, idle_d;
  logic                          req_d, enc_d, alaw_d;
  logic [adpcm_pkg::PCM_W-1:0]   data_d;
  logic [1:0]                    rate_d;
  logic [adpcm_pkg::STATE_W-1:0] state_d;
  adpcm_pkg::chan_s              cur;

  chan_mem_if mif ();

  chan_mem #(
    .DEPTH (adpcm_pkg::NUM_CH)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .clk_en_i  (clk_en_i),
    .m         (mif.mem)
  );

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else if (clk_en_i) begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Pin synchronisers; warm reset idles released
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      wr_meta_q <= 1'b1;
      wr_s      <= 1'b1;
      prev_q    <= '0;
    end else if (clk_en_i) begin
      sync1_q   <= {strobe_i, pcm_shift_clock_i, adpcm_shift_clock_i, direction_select_i,
                    companding_select_i, enable_i, init_i, rate_select_high_i,
                    rate_select_low_i, pcm_serial_in_i, adpcm_serial_in_i};
      sync2_q   <= sync1_q;
      wr_meta_q <= warm_reset_n_i;
      wr_s      <= wr_meta_q;
      prev_q    <= {ce_s, pck_s, ack_s};
    end
  end

  // Edge detection on synchronised strobe and shift clocks
  assign {ce_s, pck_s, ack_s, dir_s, comp_s, en_s, init_s, rhi_s, rlo_s, pin_s, ain_s} = sync2_q;
  assign ce_fall = prev_q[2] & ~ce_s;
  assign ce_rise = ~prev_q[2] & ce_s;
  assign p_fall  = prev_q[1] & ~pck_s;
  assign p_rise  = ~prev_q[1] & pck_s;
  assign a_fall  = prev_q[0] & ~ack_s;
  assign a_rise  = ~prev_q[0] & ack_s;
  assign run_ok  = (phase_q == adpcm_pkg::PH_RUN) && clk_en_i;
  assign cur     = mif.rdata;

  // Next state of the channel sequencer and serial paths
  always_comb begin
    phase_d     = phase_q;
    cnt_d       = cnt_q;
    pend_kind_d = pend_kind_q;
    out_kind_d  = out_kind_q;
    pend_rate_d = pend_rate_q;
    pend_alaw_d = pend_alaw_q;
    pcm_in_d    = pcm_in_q;
    ad_in_d     = ad_in_q;
    pcmw_d      = pcmw_q;
    adw_d       = adw_q;
    res_d       = res_q;
    aidx_d      = aidx_q;
    pidx_d      = pidx_q;
    alen_d      = alen_q;
    busy_d      = busy_q;
    chan_d      = chan_q;
    core_chan_d = core_chan_q;
    idle_d      = chan_idle_o;
    req_d       = 1'b0;
    enc_d       = core_encode_o;
    data_d      = core_data_o;
    rate_d      = core_rate_o;
    alaw_d      = core_alaw_o;
    state_d     = core_state_o;
    mif.we      = 1'b0;
    mif.waddr   = chan_q;
    mif.wdata   = adpcm_pkg::CHAN_DEFAULT;
    mif.raddr   = chan_q;
    nb          = adpcm_pkg::code_bits(cur.rate);
    code        = (cur.rate == adpcm_pkg::RATE_40) ? ad_in_q
                : {1'b0, ad_in_q[adpcm_pkg::ADPCM_W-2:0] >> (adpcm_pkg::BITS_32 - nb)};
    unique case (phase_q)
      adpcm_pkg::PH_HOLD: begin
        pcm_in_d    = '0;
        ad_in_d     = '0;
        pend_kind_d = adpcm_pkg::K_NONE;
        out_kind_d  = adpcm_pkg::K_NONE;
        busy_d      = 1'b0;
        chan_d      = '0;
        if (wr_s) begin
          phase_d = adpcm_pkg::PH_INIT;
          cnt_d   = adpcm_pkg::WARM_CYCLES;
        end
      end
      adpcm_pkg::PH_INIT: begin
        mif.we    = 1'b1;
        mif.waddr = cnt_q[adpcm_pkg::CH_W-1:0];
        if (!wr_s) begin
          phase_d = adpcm_pkg::PH_HOLD;
        end else if (cnt_q == adpcm_pkg::CNT_LAST) begin
          phase_d = adpcm_pkg::PH_RUN;
        end else begin
          cnt_d = cnt_q - adpcm_pkg::CNT_LAST;
        end
      end
      adpcm_pkg::PH_RUN: begin
        if (!wr_s) begin
          phase_d = adpcm_pkg::PH_HOLD;
        end
        // Input shift registers, MSB first
        if (ce_s && dir_s && p_fall) begin
          pcm_in_d = {pcm_in_q[adpcm_pkg::PCM_W-2:0], pin_s};
        end
        if (ce_s && !dir_s && a_fall) begin
          ad_in_d = {ad_in_q[adpcm_pkg::ADPCM_W-2:0], ain_s};
        end
        // Output bit pointers, wrap to MSB
        if (ce_rise) begin
          aidx_d = '0;
          pidx_d = '0;
        end else if (ce_s) begin
          if (a_rise) begin
            aidx_d = (aidx_q == alen_q - 3'h1) ? 3'h0 : aidx_q + 3'h1;
          end
          if (p_rise) begin
            pidx_d = pidx_q + 3'h1;
          end
        end
        // Result and state write-back from the core
        if (core_done_i && busy_q) begin
          res_d       = core_result_i;
          busy_d      = 1'b0;
          mif.we      = 1'b1;
          mif.waddr   = core_chan_q;
          mif.wdata   = '{rate: pend_rate_q, alaw: pend_alaw_q, st: core_state_i};
        end
        if (ce_fall) begin
          // Load output registers from the previous period
          out_kind_d = pend_kind_q;
          alen_d     = (pend_rate_q == adpcm_pkg::RATE_40) ? adpcm_pkg::BITS_40
                     : adpcm_pkg::BITS_32;
          unique case (pend_kind_q)
            adpcm_pkg::K_ENC: begin
              adw_d = (pend_rate_q == adpcm_pkg::RATE_40) ? res_d[adpcm_pkg::ADPCM_W-1:0]
                    : {res_d[adpcm_pkg::ADPCM_W-2:0] << (adpcm_pkg::BITS_32
                       - adpcm_pkg::code_bits(pend_rate_q)), 1'b0};
            end
            adpcm_pkg::K_DEC:  pcmw_d = res_d;
            adpcm_pkg::K_NOPA: adw_d  = adpcm_pkg::ADPCM_IDLE;
            adpcm_pkg::K_NOPP: begin
              pcmw_d = pend_alaw_q ? adpcm_pkg::PCM_IDLE_A : adpcm_pkg::PCM_IDLE_MU;
            end
            adpcm_pkg::K_NONE: out_kind_d = adpcm_pkg::K_NONE;
          endcase
          // Sample configuration and input of this period
          chan_d = chan_q + 3'h1;
          if (init_s) begin
            mif.we      = 1'b1;
            mif.waddr   = chan_q;
            mif.wdata   = '{rate: {rhi_s, rlo_s}, alaw: comp_s, st: adpcm_pkg::STATE_DEFAULT};
            pend_kind_d = adpcm_pkg::K_NONE;
            idle_d      = 1'b0;
          end else if (!en_s) begin
            pend_kind_d = dir_s ? adpcm_pkg::K_NOPA : adpcm_pkg::K_NOPP;
            pend_rate_d = {rhi_s, rlo_s};
            pend_alaw_d = comp_s;
            idle_d      = 1'b1;
          end else begin
            req_d       = 1'b1;
            enc_d       = dir_s;
            data_d      = dir_s ? pcm_in_q : {3'h0, code};
            rate_d      = cur.rate;
            alaw_d      = cur.alaw;
            state_d     = cur.st;
            core_chan_d = chan_q;
            busy_d      = 1'b1;
            pend_kind_d = dir_s ? adpcm_pkg::K_ENC : adpcm_pkg::K_DEC;
            pend_rate_d = cur.rate;
            pend_alaw_d = cur.alaw;
            idle_d      = 1'b0;
          end
        end
      end
    endcase
    // Serial outputs; off outside run and while strobe low
    ad_o_d   = adw_d[3'(adpcm_pkg::ADPCM_W - 1) - aidx_d];
    pcm_o_d  = pcmw_d[3'(adpcm_pkg::PCM_W - 1) - pidx_d];
    ad_oe_d  = ce_s && (phase_q == adpcm_pkg::PH_RUN)
            && (out_kind_d == adpcm_pkg::K_ENC || out_kind_d == adpcm_pkg::K_NOPA);
    pcm_oe_d = ce_s && (phase_q == adpcm_pkg::PH_RUN)
            && (out_kind_d == adpcm_pkg::K_DEC || out_kind_d == adpcm_pkg::K_NOPP);
  end

  // State registers; power-on starts the long init
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_q               <= adpcm_pkg::PH_INIT;
      cnt_q                 <= adpcm_pkg::POR_CYCLES;
      pend_kind_q           <= adpcm_pkg::K_NONE;
      out_kind_q            <= adpcm_pkg::K_NONE;
      pend_rate_q           <= adpcm_pkg::RATE_32;
      pend_alaw_q           <= 1'b0;
      pcm_in_q              <= '0;
      ad_in_q               <= '0;
      pcmw_q                <= '0;
      adw_q                 <= '0;
      res_q                 <= '0;
      aidx_q                <= '0;
      pidx_q                <= '0;
      alen_q                <= adpcm_pkg::BITS_32;
      busy_q                <= 1'b0;
      chan_q                <= '0;
      core_chan_q           <= '0;
      adpcm_serial_out_o    <= 1'b0;
      adpcm_serial_out_oe_o <= 1'b0;
      pcm_serial_out_o      <= 1'b0;
      pcm_serial_out_oe_o   <= 1'b0;
      init_busy_o           <= 1'b1;
      chan_idle_o           <= 1'b0;
      core_req_o            <= 1'b0;
      core_encode_o         <= 1'b0;
      core_data_o           <= '0;
      core_rate_o           <= adpcm_pkg::RATE_32;
      core_alaw_o           <= 1'b0;
      core_state_o          <= '0;
    end else if (clk_en_i) begin
      phase_q               <= phase_d;
      cnt_q                 <= cnt_d;
      pend_kind_q           <= pend_kind_d;
      out_kind_q            <= out_kind_d;
      pend_rate_q           <= pend_rate_d;
      pend_alaw_q           <= pend_alaw_d;
      pcm_in_q              <= pcm_in_d;
      ad_in_q               <= ad_in_d;
      pcmw_q                <= pcmw_d;
      adw_q                 <= adw_d;
      res_q                 <= res_d;
      aidx_q                <= aidx_d;
      pidx_q                <= pidx_d;
      alen_q                <= alen_d;
      busy_q                <= busy_d;
      chan_q                <= chan_d;
      core_chan_q           <= core_chan_d;
      adpcm_serial_out_o    <= ad_o_d;
      adpcm_serial_out_oe_o <= ad_oe_d;
      pcm_serial_out_o      <= pcm_o_d;
      pcm_serial_out_oe_o   <= pcm_oe_d;
      init_busy_o           <= phase_d != adpcm_pkg::PH_RUN;
      chan_idle_o           <= idle_d;
      core_req_o            <= req_d;
      core_encode_o         <= enc_d;
      core_data_o           <= data_d;
      core_rate_o           <= rate_d;
      core_alaw_o           <= alaw_d;
      core_state_o          <= state_d;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_fall_dis;
    ce_fall && run_ok && !init_s && !en_s;
  endsequence
  sequence s_fall_dec;
    ce_fall && run_ok && !init_s && en_s && !dir_s;
  endsequence

  a_por_len: assert property ($rose(rst_n) |-> phase_q == adpcm_pkg::PH_INIT
    && cnt_q == adpcm_pkg::POR_CYCLES) else $error("power-on init length wrong");
  a_warm_len: assert property ((phase_q == adpcm_pkg::PH_HOLD && wr_s && clk_en_i)
    |=> phase_q == adpcm_pkg::PH_INIT && cnt_q == adpcm_pkg::WARM_CYCLES)
    else $error("warm init length wrong");
  a_init_done: assert property ((phase_q == adpcm_pkg::PH_INIT && wr_s
    && cnt_q == adpcm_pkg::CNT_LAST && clk_en_i) |=> phase_q == adpcm_pkg::PH_RUN
    && !core_req_o) else $error("init did not end in run");
  a_tri_init: assert property ((phase_q != adpcm_pkg::PH_RUN && clk_en_i)
    |=> !adpcm_serial_out_oe_o && !pcm_serial_out_oe_o) else $error("output on during init");
  a_init_default: assert property ((phase_q == adpcm_pkg::PH_INIT && wr_s)
    |-> mif.we && mif.wdata.st == adpcm_pkg::STATE_DEFAULT) else $error("init not default");
  a_cfg_init: assert property ((ce_fall && run_ok && init_s) |-> mif.we
    && mif.waddr == chan_q && mif.wdata.rate == {rhi_s, rlo_s} && mif.wdata.alaw == comp_s)
    else $error("channel init config not stored");
  a_nop_keep: assert property (s_fall_dis |=> !core_req_o [*2])
    else $error("disabled channel started core");
  a_nop_idle: assert property (s_fall_dis |=> chan_idle_o)
    else $error("idle not flagged after disabled cycle");
  a_dec_path: assert property (s_fall_dec |=> core_req_o && !core_encode_o ##1 !core_req_o)
    else $error("decode request not issued");
  a_nop_pcm: assert property ((ce_fall && run_ok && pend_kind_q == adpcm_pkg::K_NOPP)
    |=> pcmw_q == ($past(pend_alaw_q) ? adpcm_pkg::PCM_IDLE_A : adpcm_pkg::PCM_IDLE_MU))
    else $error("idle PCM pattern wrong");
  a_nop_low: assert property ((out_kind_q == adpcm_pkg::K_NOPA && adpcm_serial_out_oe_o
    && $past(out_kind_q) == adpcm_pkg::K_NOPA) |-> !adpcm_serial_out_o)
    else $error("ADPCM output high after disabled cycle");
  a_ad_wrap: assert property ((a_rise && ce_s && !ce_rise && run_ok
    && aidx_q == alen_q - 3'h1) |=> aidx_q == 3'h0) else $error("ADPCM output did not wrap");
  a_pad_def: assert property ((out_kind_q == adpcm_pkg::K_ENC
    && alen_q == adpcm_pkg::BITS_32) |-> !adw_q[0]) else $error("pad slot not defined");
endmodule

//--- sim/frame_ctl_model.sv
`timescale 1ns/1ns
module frame_ctl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       core_req_i,
  input  wire logic [7:0] core_data_i,
  input  wire logic [3:0] sdo_i,
  output logic            strobe_o,
  output logic            sck_o,
  output logic [5:0]      cfg_o,
  output logic [1:0]      sdi_o,
  output logic            core_done_o,
  output logic [7:0]      core_result_o
);
  logic [3:0] wait_q;
  // Idle levels: strobe low, clocks high, data low
  initial begin
    strobe_o = 1'b0;
    sck_o = 1'b1;
    cfg_o = 6'h00;
    sdi_o = 2'h0;
    core_done_o = 1'b0;
    core_result_o = 8'h00;
    wait_q = 4'h0;
  end
  // Core stand-in answers ten cycles after a request
  always @(posedge ref_clk_i) begin
    core_done_o <= 1'b0;
    if (core_req_i) begin
      wait_q <= 4'hA;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      core_done_o <= (wait_q == 4'h1);
      core_result_o <= core_data_i ^ 8'h5A;
    end
  end
  // Strobe-high with eight shift pulses, outputs sampled before each rise
  task automatic frame(input logic [5:0] cfg, input logic [7:0] pcm,
                       output logic [7:0] ab, output logic [7:0] ao,
                       output logic [7:0] pb, output logic [7:0] po);
    @(posedge ref_clk_i);
    cfg_o <= cfg;
    strobe_o <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= {pcm[i], pcm[i]};
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      {ab[i], ao[i], pb[i], po[i]} = sdo_i;
      @(posedge ref_clk_i);
      sck_o <= 1'b1;
    end
    repeat (4) @(posedge ref_clk_i);
    strobe_o <= 1'b0;
    sdi_o <= ~sdi_o; // Released data shows no stale level
    repeat (40) @(posedge ref_clk_i);
  endtask
endmodule

//--- sim/adpcm_channel_control_bench.sv
`timescale 1ns/1ns
module adpcm_channel_control_bench;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       warm_reset_n_i = 1'b1;
  logic       strobe, sck, core_req, core_done, init_busy, chan_idle;
  logic [5:0] cfg;
  logic [1:0] sdi;
  wire  [3:0] sdo;
  logic [7:0] core_data, core_result;
  logic       core_enc, core_alaw;
  logic [1:0] core_rate;
  logic [15:0] core_st;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;

  adpcm_channel_control i_adpcm_channel_control (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .strobe_i(strobe),
    .pcm_shift_clock_i(sck), .adpcm_shift_clock_i(sck), .direction_select_i(cfg[5]),
    .companding_select_i(cfg[4]), .enable_i(cfg[3]), .init_i(cfg[2]),
    .rate_select_high_i(cfg[1]), .rate_select_low_i(cfg[0]),
    .warm_reset_n_i(warm_reset_n_i), .pcm_serial_in_i(sdi[1]), .adpcm_serial_in_i(sdi[0]),
    .core_done_i(core_done), .core_result_i(core_result), .core_state_i(16'h0000),
    .adpcm_serial_out_o(sdo[3]), .adpcm_serial_out_oe_o(sdo[2]),
    .pcm_serial_out_o(sdo[1]), .pcm_serial_out_oe_o(sdo[0]), .init_busy_o(init_busy),
    .chan_idle_o(chan_idle), .core_req_o(core_req), .core_encode_o(core_enc),
    .core_data_o(core_data), .core_rate_o(core_rate), .core_alaw_o(core_alaw),
    .core_state_o(core_st)
  );
  frame_ctl_model i_frame_ctl_model (
    .ref_clk_i(ref_clk_i), .core_req_i(core_req), .core_data_i(core_data), .sdo_i(sdo),
    .strobe_o(strobe), .sck_o(sck), .cfg_o(cfg), .sdi_o(sdi), .core_done_o(core_done),
    .core_result_o(core_result)
  );
  // Clock and hang guard
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cold start: outputs off until the long init ends
  task automatic t_power_on();
    int   n;
    logic off;
    n = 0;
    off = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    while (init_busy !== 1'b0 && n < 2100) begin
      @(negedge ref_clk_i);
      n++;
      if (sdo[2] !== 1'b0 || sdo[0] !== 1'b0) off = 1'b0;
    end
    check("cold_oe_off", 16'h1, {15'h0, off});
    check("cold_len", 16'h1, {15'h0, n >= 2000 && n <= 2008});
  endtask
  // Warm reset pulse of two cycles, then memory init
  task automatic t_warm_reset();
    int n;
    n = 0;
    @(posedge ref_clk_i);
    warm_reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    warm_reset_n_i <= 1'b1;
    while (init_busy !== 1'b1 && n < 10) begin
      @(negedge ref_clk_i);
      n++;
    end
    while (init_busy !== 1'b0 && n < 800) begin
      @(negedge ref_clk_i);
      n++;
    end
    check("warm_len", 16'h1, {15'h0, n >= 726 && n <= 734});
    repeat (6) @(posedge ref_clk_i);
  endtask
  // Init channel 0 at 40k, then disabled cycles; a fall shows two periods later
  task automatic t_nop_patterns();
    logic [7:0] ab, ao, pb, po;
    logic [5:0] c, pc, ppc;
    pc = 6'h00;
    ppc = 6'h00;
    i_frame_ctl_model.frame(6'b001111, 8'h00, ab, ao, pb, po);
    for (int j = 1; j < 8; j++) begin
      c = {j[0], j[1], 4'b0011};
      i_frame_ctl_model.frame(c, 8'h00, ab, ao, pb, po);
      if (j < 3) begin
        check("init_no_out", 16'h0, {8'h0, ao | po});
      end else if (ppc[5]) begin
        check("nop_adpcm", 16'h00FF, {ab, ao});
      end else begin
        check("nop_pcm", {ppc[4] ? 8'hD5 : 8'hFF, 8'hFF}, {pb, po});
      end
      check("idle_set", 16'h1, {15'h0, chan_idle});
      ppc = pc;
      pc = c;
    end
  endtask
  // Encodes on a 40k and a 32k channel, eight pulses show the wrap; then a decode
  task automatic t_encode_wrap();
    logic [7:0] ab, ao, pb, po;
    i_frame_ctl_model.frame(6'b101000, 8'h3C, ab, ao, pb, po);
    check("nop_pcm_last", 16'hD5FF, {pb, po});
    check("idle_clear", 16'h0, {15'h0, chan_idle});
    check("enc_cfg_40k", 16'h000B, {12'h0, core_enc, core_alaw, core_rate});
    check("enc_data", 16'h003C, {8'h0, core_data});
    check("enc_state_a", 16'h0000, core_st);
    i_frame_ctl_model.frame(6'b101011, 8'h53, ab, ao, pb, po);
    check("nop_adpcm_last", 16'h00FF, {ab, ao});
    check("enc_cfg_32k", 16'h0008, {12'h0, core_enc, core_alaw, core_rate});
    check("enc_state_b", 16'h0000, core_st);
    i_frame_ctl_model.frame(6'b001111, 8'h00, ab, ao, pb, po);
    check("wrap_40k", 16'h31FF, {ab, ao});
    i_frame_ctl_model.frame(6'b001000, 8'h07, ab, ao, pb, po);
    check("wrap_32k", 16'h99FF, {ab, ao});
    check("dec_fields", 16'h0007, {4'h0, core_enc, core_alaw, core_rate, core_data});
    i_frame_ctl_model.frame(6'b000000, 8'h00, ab, ao, pb, po);
    check("init_no_out_c", 16'h0, {8'h0, ao | po});
    i_frame_ctl_model.frame(6'b000000, 8'h00, ab, ao, pb, po);
    check("dec_pcm", 16'h5DFF, {pb, po});
    check("dec_ad_off", 16'h0, {8'h0, ao});
  endtask
  // Main sequence
  initial begin
    t_power_on();
    t_warm_reset();
    t_nop_patterns();
    t_encode_wrap();
    wrap_up();
  end
endmodule
